// >>> pkg/ude_defs.svh
// Register offsets, field positions and reset values of the endpoint block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef UDE_DEFS_SVH
`define UDE_DEFS_SVH

// Byte offsets of the registers.
`define UDE_OFF_CTRL   8'h00
`define UDE_OFF_INFLG  8'h04
`define UDE_OFF_OUTFLG 8'h08
`define UDE_OFF_SIZE0  8'h0C
`define UDE_OFF_CFG    8'h10

// Endpoint control fields.
`define UDE_B_ENA   31
`define UDE_B_DIS   30
`define UDE_B_ONE   29
`define UDE_B_ZERO  28
`define UDE_B_SETRF 27
`define UDE_B_CLRRF 26
`define UDE_B_STALL 21
`define UDE_B_FWD   20
`define UDE_B_KINDH 19
`define UDE_B_KINDL 18
`define UDE_B_RFS   17
`define UDE_B_TGL   16
`define UDE_B_ACT   15
`define UDE_B_MAXH  10

// Event flag positions of the IN and OUT flag registers.
`define UDE_F_FLOW  7
`define UDE_F_NAKEF 6
`define UDE_F_DRY   4
`define UDE_F_OFF   4
`define UDE_F_TMO   3
`define UDE_F_SUPD  3
`define UDE_F_BERR  2
`define UDE_F_DISD  1
`define UDE_F_DONE  0
`define UDE_F_NYET  14
`define UDE_F_NAKS  13
`define UDE_F_B2B   6

// Writable flag masks, reset values and the back-to-back SETUP limit.
`define UDE_IN_MASK  32'h0000005F
`define UDE_OUT_MASK 32'h0000605F
`define UDE_RST_MAXPKT 11'h000
`define UDE_SETUP_MAX 2'h3

`endif

// >>> pkg/ude_pkg.sv
// Types shared by the endpoint block: transfer kinds, answers, bus states.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ude_pkg;
  // Transfer kind of the endpoint.
  typedef enum logic [1:0] {
    KIND_CTRL = 2'b00,
    KIND_ISO  = 2'b01,
    KIND_BULK = 2'b10,
    KIND_INTR = 2'b11
  } ude_kind_t;
  // Handshake chosen for a token.
  typedef enum logic [2:0] {
    RESP_NONE  = 3'b000,
    RESP_ACK   = 3'b001,
    RESP_NAK   = 3'b010,
    RESP_STALL = 3'b011,
    RESP_DATA  = 3'b100,
    RESP_ZLP   = 3'b101
  } ude_resp_t;
  // Bus slave phase.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR   = 2'b01,
    BUS_RD   = 2'b10,
    BUS_RDY  = 2'b11
  } ude_bus_t;
endpackage
`default_nettype wire

// >>> logic/ude_endpoint_ctrl.sv
// Device endpoint control: control word, IN and OUT event flags,
// endpoint 0 IN transfer counters and the token answer logic.
// Assumes the packet engine drives its events on hclk as one-cycle pulses.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`default_nettype none
`include "ude_defs.svh"

module ude_endpoint_ctrl
  import ude_pkg::*;
#(
  parameter int unsigned EP_NUM      = 1,  // Endpoint number.
  parameter bit          HS_INSTANCE = 1'b1 // Fast instance with DMA.
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Tokens and engine levels.
  input  wire logic        tok_setup,
  input  wire logic        tok_in,
  input  wire logic        tok_out,
  input  wire logic        in_fifo_empty,
  input  wire logic        in_fifo_half,
  input  wire logic        rx_fifo_room,
  input  wire logic        global_in_nak,
  input  wire logic        global_out_nak,
  // Engine event pulses.
  input  wire logic        data_ok_evt,
  input  wire logic        setup_done_evt,
  input  wire logic        in_timeout_evt,
  input  wire logic        in_bus_err_evt,
  input  wire logic        out_bus_err_evt,
  input  wire logic        in_xfer_done_evt,
  input  wire logic        out_xfer_done_evt,
  input  wire logic        nyet_sent_evt,
  input  wire logic        nak_rcvd_evt,
  input  wire logic        usb_bus_reset,
  input  wire logic        pkt_read_evt,
  input  wire logic        pkt_written_evt,
  input  wire logic [6:0]  pkt_bytes,
  // Answers and status.
  output ude_resp_t        hs_resp,
  output logic             forward_unchecked,
  output logic             endpoint_enable_bit,
  output logic             any_in_endpoint_event,
  output logic             any_out_endpoint_event
);

  // True when the latched word address selects the given offset.
  function automatic logic ude_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Bus phase and latched address.
  ude_bus_t    bus_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_reg;

  // Control word state.
  logic        enable_reg;
  logic        dis_req_reg;
  logic        dis_done_reg;
  logic        stall_reg;
  logic        unchecked_forward_mode_reg;
  ude_kind_t   transfer_kind_reg;
  logic        refusing_flag_reg;
  logic        refusing_d_reg;
  logic        next_data_toggle_reg;
  logic        endpoint_active_reg;
  logic [10:0] max_packet_bytes_reg;
  logic        fifo_level_reg;  // 1: flag on fully empty.
  logic        dma_mode_reg;

  // Event flags and counters.
  logic [31:0] in_flags_reg;
  logic [31:0] out_flags_reg;
  logic [1:0]  setup_cnt_reg;
  logic        setup_pend_reg;
  logic [1:0]  packet_counter_reg;
  logic [6:0]  byte_counter_reg;

  // Decoded strobes and events.
  logic        take;
  logic        wr_en;
  logic [31:0] rd_mux;
  logic        tx_fifo_low;
  logic        is_iso;
  logic        in_refused;
  logic        bytes_zero_evt;
  logic [31:0] in_set;
  logic [31:0] in_clr;
  logic [31:0] out_set;
  logic [31:0] out_clr;

  assign take  = hsel && htrans[1] && hready;
  assign wr_en = (bus_reg == BUS_WR);
  assign is_iso = (transfer_kind_reg == KIND_ISO);
  // Reads insert one wait state so a write just before is seen.
  assign hreadyout = (bus_reg != BUS_RD);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Bus phase tracker; hsize is ignored since only words are used.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg  <= BUS_IDLE;
      addr_reg <= 8'h00;
    end else begin
      case (bus_reg)
        BUS_RD: begin
          bus_reg <= BUS_RDY;
        end
        BUS_IDLE, BUS_WR, BUS_RDY: begin
          if (take) begin
            addr_reg <= haddr[7:0];
            bus_reg  <= hwrite ? BUS_WR : BUS_RD;
          end else begin
            bus_reg <= BUS_IDLE;
          end
        end
        default: begin
          bus_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read mux; unmapped words read zero.
  always_comb begin
    rd_mux = 32'h00000000;
    if (ude_hit(addr_reg, `UDE_OFF_CTRL)) begin
      rd_mux[`UDE_B_ENA]   = enable_reg;
      rd_mux[`UDE_B_DIS]   = dis_req_reg;
      rd_mux[`UDE_B_STALL] = stall_reg;
      rd_mux[`UDE_B_FWD]   = unchecked_forward_mode_reg;
      rd_mux[`UDE_B_KINDH:`UDE_B_KINDL] = transfer_kind_reg;
      rd_mux[`UDE_B_RFS]   = refusing_flag_reg;
      rd_mux[`UDE_B_TGL]   = next_data_toggle_reg;
      rd_mux[`UDE_B_ACT]   = endpoint_active_reg;
      rd_mux[`UDE_B_MAXH:0] = max_packet_bytes_reg;
    end else if (ude_hit(addr_reg, `UDE_OFF_INFLG)) begin
      rd_mux = in_flags_reg;
      rd_mux[`UDE_F_FLOW] = tx_fifo_low;
    end else if (ude_hit(addr_reg, `UDE_OFF_OUTFLG)) begin
      rd_mux = out_flags_reg;
    end else if (ude_hit(addr_reg, `UDE_OFF_SIZE0)) begin
      rd_mux[20:19] = packet_counter_reg;
      rd_mux[6:0]   = byte_counter_reg;
    end else if (ude_hit(addr_reg, `UDE_OFF_CFG)) begin
      rd_mux[1:0] = {dma_mode_reg, fifo_level_reg};
    end
  end

  // Read data is caught during the wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (bus_reg == BUS_RD) begin
      hrdata_reg <= rd_mux;
    end
  end

  // Token answers; stall outranks every NAK, SETUP is always taken.
  always_comb begin
    in_refused = refusing_flag_reg || global_in_nak || in_fifo_empty;
    hs_resp    = RESP_NONE;
    if (tok_setup) begin
      hs_resp = RESP_ACK;
    end else if ((tok_in || tok_out) && stall_reg) begin
      hs_resp = RESP_STALL;
    end else if (tok_out) begin
      // Room in the receive FIFO does not help a refusing endpoint.
      hs_resp = (refusing_flag_reg || global_out_nak || !rx_fifo_room)
                ? RESP_NAK : RESP_ACK;
    end else if (tok_in) begin
      if (in_refused) begin
        hs_resp = is_iso ? RESP_ZLP : RESP_NAK;
      end else begin
        hs_resp = RESP_DATA;
      end
    end
  end

  // The FIFO-low level follows the configured threshold.
  assign tx_fifo_low = fifo_level_reg ? in_fifo_empty : in_fifo_half;

  // Software fields of the control word and the configuration word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_reg                  <= 1'b0;
      unchecked_forward_mode_reg <= 1'b0;
      transfer_kind_reg          <= KIND_CTRL;
      max_packet_bytes_reg       <= `UDE_RST_MAXPKT;
      fifo_level_reg             <= 1'b0;
      dma_mode_reg               <= 1'b0;
    end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)) begin
      // Hardware never touches stall; only this write clears it.
      stall_reg                  <= hwdata[`UDE_B_STALL];
      unchecked_forward_mode_reg <= hwdata[`UDE_B_FWD];
      transfer_kind_reg <= ude_kind_t'(hwdata[`UDE_B_KINDH:`UDE_B_KINDL]);
      max_packet_bytes_reg       <= hwdata[`UDE_B_MAXH:0];
    end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CFG)) begin
      fifo_level_reg <= hwdata[0];
      dma_mode_reg   <= hwdata[1];
    end
  end

  assign forward_unchecked = unchecked_forward_mode_reg;

  // Endpoint active: endpoint 0 comes up active and survives bus reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      endpoint_active_reg <= (EP_NUM == 0);
    end else if (usb_bus_reset && (EP_NUM != 0)) begin
      endpoint_active_reg <= 1'b0;
    end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)) begin
      endpoint_active_reg <= hwdata[`UDE_B_ACT];
    end
  end

  // Enable and disable request; both are write-one-to-set.
  // Enable drops one cycle before the matching flag appears.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg   <= 1'b0;
      dis_req_reg  <= 1'b0;
      dis_done_reg <= 1'b0;
    end else begin
      dis_done_reg <= dis_req_reg;
      if (setup_done_evt || dis_req_reg) begin
        enable_reg  <= 1'b0;
        dis_req_reg <= 1'b0;
      end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)) begin
        if (hwdata[`UDE_B_ENA]) begin
          enable_reg <= 1'b1;
        end
        // A disable request only counts while the endpoint is on.
        if (hwdata[`UDE_B_DIS] && enable_reg) begin
          dis_req_reg <= 1'b1;
        end
      end
    end
  end

  assign endpoint_enable_bit = enable_reg;

  // Refusing flag: hardware sets win over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refusing_flag_reg <= 1'b0;
      refusing_d_reg    <= 1'b0;
    end else begin
      refusing_d_reg <= refusing_flag_reg;
      if (in_xfer_done_evt || out_xfer_done_evt || tok_setup) begin
        refusing_flag_reg <= 1'b1;
      end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)) begin
        if (hwdata[`UDE_B_SETRF]) begin
          refusing_flag_reg <= 1'b1;
        end else if (hwdata[`UDE_B_CLRRF]) begin
          refusing_flag_reg <= 1'b0;
        end
      end
    end
  end

  // Next data toggle, or frame parity on isochronous endpoints.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_data_toggle_reg <= 1'b0;
    end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)
                 && (hwdata[`UDE_B_ONE] || hwdata[`UDE_B_ZERO])) begin
      // Same strobes force DATA1/odd or DATA0/even.
      next_data_toggle_reg <= hwdata[`UDE_B_ONE];
    end else if (data_ok_evt && !is_iso) begin
      next_data_toggle_reg <= ~next_data_toggle_reg;
    end
  end

  // Back-to-back SETUP counter; any data token ends the burst.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_cnt_reg  <= 2'h0;
      setup_pend_reg <= 1'b0;
    end else begin
      setup_pend_reg <= setup_done_evt;
      if (tok_in || tok_out || setup_done_evt) begin
        setup_cnt_reg <= 2'h0;
      end else if (tok_setup && (setup_cnt_reg != `UDE_SETUP_MAX)) begin
        setup_cnt_reg <= setup_cnt_reg + 2'h1;
      end
    end
  end

  // Endpoint 0 IN counters; software may load them only while off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      packet_counter_reg <= 2'h0;
      byte_counter_reg   <= 7'h00;
    end else if (wr_en && ude_hit(addr_reg, `UDE_OFF_SIZE0) && !enable_reg) begin
      // Once enabled the hardware owns the counts; a stray write must not stall them.
      packet_counter_reg <= hwdata[20:19];
      byte_counter_reg   <= hwdata[6:0];
    end else begin
      if (pkt_read_evt && (packet_counter_reg != 2'h0)) begin
        packet_counter_reg <= packet_counter_reg - 2'h1;
      end
      if (pkt_written_evt) begin
        // Saturate so a short final packet cannot wrap the count.
        byte_counter_reg <= (byte_counter_reg > pkt_bytes)
                            ? byte_counter_reg - pkt_bytes : 7'h00;
      end
    end
  end

  assign bytes_zero_evt = pkt_written_evt && (byte_counter_reg != 7'h00)
                          && (byte_counter_reg <= pkt_bytes)
                          && !(wr_en && ude_hit(addr_reg, `UDE_OFF_SIZE0) && !enable_reg);

  // Set and clear vectors for the IN flags.
  always_comb begin
    in_set = 32'h00000000;
    in_clr = 32'h00000000;
    in_set[`UDE_F_NAKEF] = refusing_flag_reg && !refusing_d_reg
                           && enable_reg;
    in_set[`UDE_F_DRY]  = tok_in && in_fifo_empty;
    in_set[`UDE_F_TMO]  = in_timeout_evt
                          && (transfer_kind_reg == KIND_CTRL);
    in_set[`UDE_F_BERR] = in_bus_err_evt && HS_INSTANCE
                          && dma_mode_reg;
    in_set[`UDE_F_DISD] = dis_done_reg;
    in_set[`UDE_F_DONE] = in_xfer_done_evt || bytes_zero_evt;
    if (wr_en && ude_hit(addr_reg, `UDE_OFF_INFLG)) begin
      in_clr = hwdata & `UDE_IN_MASK;
    end
    if (wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL) && hwdata[`UDE_B_CLRRF]) begin
      in_clr[`UDE_F_NAKEF] = 1'b1;
    end
  end

  // Set and clear vectors for the OUT flags.
  always_comb begin
    out_set = 32'h00000000;
    out_clr = 32'h00000000;
    out_set[`UDE_F_NYET] = nyet_sent_evt && !is_iso;
    out_set[`UDE_F_NAKS] = nak_rcvd_evt || (hs_resp == RESP_NAK)
                           || (hs_resp == RESP_ZLP);
    out_set[`UDE_F_B2B]  = tok_setup
                           && (setup_cnt_reg == `UDE_SETUP_MAX);
    out_set[`UDE_F_OFF]  = tok_out && !enable_reg
                           && (transfer_kind_reg == KIND_CTRL);
    out_set[`UDE_F_SUPD] = setup_pend_reg;
    out_set[`UDE_F_BERR] = out_bus_err_evt && HS_INSTANCE
                           && dma_mode_reg;
    out_set[`UDE_F_DISD] = dis_done_reg;
    out_set[`UDE_F_DONE] = out_xfer_done_evt;
    if (wr_en && ude_hit(addr_reg, `UDE_OFF_OUTFLG)) begin
      out_clr = hwdata & `UDE_OUT_MASK;
    end
  end

  // Sticky flags: a set in the clearing cycle survives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_flags_reg  <= 32'h00000000;
      out_flags_reg <= 32'h00000000;
    end else begin
      in_flags_reg  <= (in_flags_reg & ~in_clr) | in_set;
      out_flags_reg <= (out_flags_reg & ~out_clr) | out_set;
    end
  end

  // Summary lines fall as soon as the last flag is cleared.
  assign any_in_endpoint_event  = |in_flags_reg;
  assign any_out_endpoint_event = |out_flags_reg;

  // Checks on the answer logic and the flags.
  stall_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tok_in || tok_out) && !tok_setup && stall_reg |-> hs_resp == RESP_STALL)
    else $error("stalled endpoint did not stall");
  setup_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tok_setup |-> hs_resp == RESP_ACK ##1 refusing_flag_reg)
    else $error("setup not acked or refusal not set");
  out_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tok_out && !tok_setup && !stall_reg && refusing_flag_reg
    |-> hs_resp == RESP_NAK)
    else $error("refusing endpoint accepted data");
  iso_zlp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tok_in && !tok_setup && !stall_reg && refusing_flag_reg
    |-> hs_resp == (is_iso ? RESP_ZLP : RESP_NAK))
    else $error("refusing IN endpoint sent data");
  bus_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    usb_bus_reset |=> endpoint_active_reg == (EP_NUM == 0))
    else $error("active flag wrong after bus reset");
  dis_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(out_flags_reg[`UDE_F_DISD]) || $rose(out_flags_reg[`UDE_F_SUPD])
    |-> !$past(enable_reg))
    else $error("flag raised while endpoint still enabled");
  set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    in_set[`UDE_F_DONE] |=> in_flags_reg[`UDE_F_DONE] ##1 1'b1)
    else $error("raised flag lost to a clear");
  summary_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && ude_hit(addr_reg, `UDE_OFF_OUTFLG) && (out_set == 32'h0)
    && ((out_flags_reg & ~hwdata) == 32'h0) |=> !any_out_endpoint_event)
    else $error("summary stayed set after clear");
  byte_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bytes_zero_evt |=> byte_counter_reg == 7'h00 && in_flags_reg[`UDE_F_DONE])
    else $error("byte count zero not flagged");
  stall_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stall_reg && !(wr_en && ude_hit(addr_reg, `UDE_OFF_CTRL)) |=> stall_reg)
    else $error("stall cleared without software");

  // Main scenarios seen in simulation.
  setup_burst_c: cover property (@(posedge hclk) disable iff (!hresetn)
    tok_setup && (setup_cnt_reg == `UDE_SETUP_MAX));
  disable_c: cover property (@(posedge hclk) disable iff (!hresetn)
    dis_req_reg ##2 out_flags_reg[`UDE_F_DISD]);
  iso_zlp_c: cover property (@(posedge hclk) disable iff (!hresetn)
    hs_resp == RESP_ZLP);
  ep0_done_c: cover property (@(posedge hclk) disable iff (!hresetn)
    bytes_zero_evt);

endmodule // ude_endpoint_ctrl
`default_nettype wire

// >>> tb/ude_usb_host.sv
// Host-side token source for the endpoint bench.
// Assumes single-cycle token pulses answered in the token cycle.
`default_nettype none
module ude_usb_host
  import ude_pkg::*;
(
  // Clock and the endpoint answer.
  input  wire logic      hclk,
  input  wire ude_resp_t hs_resp,
  // Token pulses.
  output logic           tok_setup,
  output logic           tok_in,
  output logic           tok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Tokens rest low between transactions.
  initial {tok_setup, tok_in, tok_out} = 3'h0;
  // Sends token k (0 setup, 1 in, 2 out); the idle cycle after keeps one token per cycle.
  task automatic send(input int k, output ude_resp_t r);
    {tok_setup, tok_in, tok_out} <= 3'h4 >> k;
    @(posedge hclk);
    r = hs_resp;
    {tok_setup, tok_in, tok_out} <= 3'h0;
    @(posedge hclk);
  endtask
endmodule // ude_usb_host
`default_nettype wire

// >>> tb/ude_endpoint_ctrl_bench.sv
// Self-checking bench for the endpoint block: registers, answers, flags, counters.
// Assumes the host model above and a single 200 MHz clock.
`default_nettype none
module ude_endpoint_ctrl_bench;
  import ude_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, t_setup, t_in, t_out;
  logic        fifo_empty, fifo_half, rx_room, fwd, ena, any_in, any_out;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, d, v;
  logic [11:0] ev;        // One bit per engine event pulse.
  logic [6:0]  pkt_bytes; // Byte count handed with a written packet.
  ude_resp_t   hs_resp, r;
  int          n_mismatch, n_tests;
  ude_endpoint_ctrl u_ude_endpoint_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tok_setup(t_setup), .tok_in(t_in), .tok_out(t_out), .in_fifo_empty(fifo_empty),
    .in_fifo_half(fifo_half), .rx_fifo_room(rx_room), .global_in_nak(1'b0),
    .global_out_nak(1'b0), .data_ok_evt(ev[0]), .setup_done_evt(ev[1]),
    .in_timeout_evt(ev[2]), .in_bus_err_evt(ev[3]), .out_bus_err_evt(ev[4]),
    .in_xfer_done_evt(ev[5]), .out_xfer_done_evt(ev[6]), .nyet_sent_evt(ev[7]),
    .nak_rcvd_evt(ev[8]), .usb_bus_reset(ev[9]), .pkt_read_evt(ev[10]),
    .pkt_written_evt(ev[11]), .pkt_bytes(pkt_bytes), .hs_resp(hs_resp),
    .forward_unchecked(fwd), .endpoint_enable_bit(ena),
    .any_in_endpoint_event(any_in), .any_out_endpoint_event(any_out));
  ude_usb_host u_ude_usb_host (.hclk(hclk), .hs_resp(hs_resp), .tok_setup(t_setup),
    .tok_in(t_in), .tok_out(t_out));
  // Free-running 5 ns clock.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Word compare; unknowns never match.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask
  // Handshake compare after one token.
  task automatic tok(input int k, input ude_resp_t e);
    u_ude_usb_host.send(k, r);
    chk("handshake", 32'(e), 32'(r));
  endtask
  // One AHB-Lite single transfer; address and data phases held until hready is seen.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk iff hreadyout);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk iff hreadyout);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask
  // One-cycle engine event on bit i.
  task automatic pulse(input int i);
    ev <= 12'h001 << i;
    @(posedge hclk);
    ev <= 12'h000;
    @(posedge hclk);
  endtask
  // Fields of the control word that read back as written.
  function automatic logic [31:0] rw_bits(input logic [31:0] x);
    return x & 32'h003C87FF;
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch; the tests need about two hundred cycles.
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {hresetn, hwrite, fifo_empty, fifo_half, htrans, ev, pkt_bytes} = '0;
    {haddr, hwdata, n_mismatch, n_tests} = '0;
    rx_room = 1'b1;
    void'($urandom(19391));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped read.
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, (i == 5) ? 8'h40 : 8'(i * 4), 32'h0, v);
      chk("reset word", 32'h0, v);
    end
    chk("hresp", 32'h0, 32'(hresp));
    // Every transfer kind with random packet size and snoop.
    for (int k = 0; k < 4; k++) begin
      v = ($urandom & 32'h7FF) | (k << 18) | 32'h8000 | (($urandom & 1) << 20);
      wr(8'h00, v);
      xfer(1'b0, 8'h00, 0, d);
      chk("control", rw_bits(v), d);
      chk("snoop", 32'(v[20]), 32'(fwd));
    end
    v = (v & ~32'h000C0000) | 32'h00080000;
    wr(8'h00, v | 32'h20000000);
    xfer(1'b0, 8'h00, 0, d);
    chk("toggle one", 32'h1, 32'(d[16]));
    wr(8'h00, v | 32'h10000000);
    xfer(1'b0, 8'h00, 0, d);
    chk("toggle zero", 32'h0, 32'(d[16]));
    wr(8'h00, v | 32'h08000000);
    xfer(1'b0, 8'h00, 0, d);
    chk("refusing", 32'h1, 32'(d[17]));
    tok(2, RESP_NAK);
    tok(1, RESP_NAK);
    tok(0, RESP_ACK);
    wr(8'h00, (v & ~32'h000C0000) | 32'h00040000 | 32'h20000000);
    tok(1, RESP_ZLP);
    xfer(1'b0, 8'h00, 0, d);
    chk("odd frame", 32'h1, 32'(d[16]));
    wr(8'h00, v | 32'h00200000);
    tok(2, RESP_STALL);
    tok(1, RESP_STALL);
    wr(8'h00, v | 32'h04000000);
    tok(2, RESP_ACK);
    tok(1, RESP_DATA);
    tok(0, RESP_ACK);
    xfer(1'b0, 8'h00, 0, d);
    chk("refusing after setup", 32'h1, 32'(d[17]));
    // OUT flags: the NAK and zero-length answers above left the NAK flag up.
    xfer(1'b0, 8'h08, 0, d);
    chk("nak sent flag", 32'h2000, d);
    wr(8'h08, 32'hFFFFFFFF);
    // Raise, keep on zero write, clear on one.
    for (int k = 7; k < 9; k++) begin
      pulse(k);
      chk("out summary", 32'h1, 32'(any_out));
      wr(8'h08, 32'h0);
      xfer(1'b0, 8'h08, 0, d);
      chk("out flags", 32'h1 << (21 - k), d);
      wr(8'h08, 32'h1 << (21 - k));
      @(posedge hclk);
      chk("out summary clear", 32'h0, 32'(any_out));
    end
    // Control kind from here on: timeout, OUT while off, dry FIFO.
    wr(8'h00, v & ~32'h000C0000);
    pulse(2);
    xfer(1'b0, 8'h04, 0, d);
    chk("timeout flag", 32'h1, 32'(d[3]));
    tok(2, RESP_NAK);
    xfer(1'b0, 8'h08, 0, d);
    chk("out while off", 32'h2010, d);
    fifo_empty <= 1'b1;
    tok(1, RESP_NAK);
    xfer(1'b0, 8'h04, 0, d);
    chk("token fifo dry", 32'h1, 32'(d[4]));
    fifo_half <= 1'b1;
    xfer(1'b0, 8'h04, 0, d);
    chk("fifo low", 32'h1, 32'(d[7]));
    wr(8'h10, 32'h1);
    fifo_empty <= 1'b0;
    xfer(1'b0, 8'h04, 0, d);
    chk("fifo low at empty level", 32'h0, 32'(d[7]));
    wr(8'h10, 32'h2);
    pulse(3);
    xfer(1'b0, 8'h04, 0, d);
    chk("bus error flag", 32'h1, 32'(d[2]));
    repeat (4) tok(0, RESP_ACK);
    xfer(1'b0, 8'h08, 0, d);
    chk("setup overflow", 32'h1, 32'(d[6]));
    pulse(9);
    xfer(1'b0, 8'h00, 0, d);
    chk("active after bus reset", 32'h0, 32'(d[15]));
    // Endpoint 0 IN counters.
    v = 32'h00100000 | 32'($urandom_range(127, 1));
    pkt_bytes <= v[6:0];
    wr(8'h0C, v);
    wr(8'h00, 32'h80000000);
    wr(8'h0C, 32'h0);
    xfer(1'b0, 8'h0C, 0, d);
    chk("size locked", v, d);
    pulse(10);
    pulse(11);
    xfer(1'b0, 8'h0C, 0, d);
    chk("counters", 32'h00080000, d);
    xfer(1'b0, 8'h04, 0, d);
    chk("done flag", 32'h1, 32'(d[0]));
    // Refusal taking effect on an enabled endpoint, then cleared by clear-refusal.
    wr(8'h00, 32'h84000000);
    wr(8'h00, 32'h88000000);
    xfer(1'b0, 8'h04, 0, d);
    chk("refusal effective", 32'h1, 32'(d[6]));
    wr(8'h00, 32'h84000000);
    xfer(1'b0, 8'h04, 0, d);
    chk("refusal effective clear", 32'h0, 32'(d[6]));
    wr(8'h00, 32'h40000000);
    repeat (2) @(posedge hclk);
    chk("enable", 32'h0, 32'(ena));
    xfer(1'b0, 8'h04, 0, d);
    chk("disabled flag", 32'h1, 32'(d[1]));
    // SETUP stage done drops enable first; transfer done sets refusal.
    wr(8'h00, 32'h80000000);
    pulse(1);
    chk("enable after setup", 32'h0, 32'(ena));
    xfer(1'b0, 8'h08, 0, d);
    chk("setup done flag", 32'h1, 32'(d[3]));
    wr(8'h00, 32'h04000000);
    pulse(6);
    xfer(1'b0, 8'h00, 0, d);
    chk("refusing after done", 32'h1, 32'(d[17]));
    xfer(1'b0, 8'h08, 0, d);
    chk("out done flag", 32'h1, 32'(d[0]));
    close_out();
  end
endmodule // ude_endpoint_ctrl_bench
`default_nettype wire
